// ---- hw/lfi_pkg.sv ----
/*
 * Shared constants and types of the low-frequency initiator mode control core.
 * It assumes a 100 MHz system clock and a 16-bit serial command word.
 */
package lfi_pkg;

	// Operating modes of the device.
	typedef enum logic [1:0] {
		M_SLEEP = 2'b00,
		M_STBY  = 2'b01,
		M_TX    = 2'b10,
		M_DIAG  = 2'b11
	} lfi_mode_t;

	// Clock and timing figures, times in their own units.
	localparam int CLK_HZ         = 100000000;
	localparam int CAR_FIXED_HZ   = 125000;
	localparam int CAR_MIN_HZ     = 110000;
	localparam int CAR_MAX_HZ     = 141600;
	localparam int DET_WIN_NS     = 2000;
	localparam int DIAG_TIME_US   = 1000;
	localparam int RATE_LO_HZ     = 2000;
	localparam int RATE_MID_HZ    = 4000;
	localparam int RATE_HI_HZ     = 8000;
	localparam int DET_WIN_CYC    = DET_WIN_NS / (1000000000 / CLK_HZ);
	localparam int DET_XTAL_EDGES = 6;
	localparam logic [9:0] PER_FIXED = 10'(CLK_HZ / CAR_FIXED_HZ);
	localparam logic [9:0] PER_MAX   = 10'(CLK_HZ / CAR_MIN_HZ);
	localparam logic [9:0] PER_MIN   = 10'((CLK_HZ + CAR_MAX_HZ - 1) / CAR_MAX_HZ);

	// Command word layout: opcode on top, argument below.
	localparam int WORD_W   = 16;
	localparam int OP_LSB   = 12;
	localparam logic [3:0] OP_NOP   = 4'h0;
	localparam logic [3:0] OP_CFG   = 4'h1;
	localparam logic [3:0] OP_MOD   = 4'h2;
	localparam logic [3:0] OP_TX    = 4'h3;
	localparam logic [3:0] OP_DIAG  = 4'h4;
	localparam logic [3:0] OP_SLEEP = 4'h5;
	localparam logic [3:0] OP_CLR   = 4'h6;
	localparam int CFG_FIXED_BIT = 11;
	localparam int CFG_DUTY_LSB  = 9;
	localparam int MOD_ASK_BIT   = 2;
	localparam int MOD_PSK_BIT   = 3;
	localparam int MOD_RATE_LSB  = 4;
	localparam int MOD_DSEL_BIT  = 6;

	// Fault input and flag bit positions.
	localparam int FI_UVDD = 0;
	localparam int FI_UVS  = 1;
	localparam int FI_PREW = 2;
	localparam int FI_OTMP = 3;
	localparam int FI_OCUR = 4;
	localparam int FI_SHRT = 5;
	localparam int FI_OPEN = 6;
	localparam int FL_UV   = 0;
	localparam int FL_PREW = 1;
	localparam int FL_OTMP = 2;
	localparam int FL_OCUR = 3;
	localparam int FL_SPI  = 4;
	localparam int FL_SHRT = 5;
	localparam int FL_OPEN = 6;

	// Transmission configuration set.
	typedef struct packed {
		logic       fixed;
		logic [1:0] duty;
		logic [7:0] per_code;
		logic [1:0] chan_en;
		logic       ask_en;
		logic       psk_en;
		logic [1:0] rate;
		logic       dsel;
	} lfi_cfg_t;

	localparam lfi_cfg_t CFG_RST = '{fixed: 1'b1, duty: 2'h3, per_code: 8'h00,
		chan_en: 2'h0, ask_en: 1'b0, psk_en: 1'b0, rate: 2'h0, dsel: 1'b0};

	// System clock domain state of the control core.
	typedef struct packed {
		lfi_mode_t   mode;
		lfi_cfg_t    cfg;
		logic [2:0]  clk_s;
		logic [2:0]  wake_s;
		logic [1:0]  rdi_s;
		logic [1:0]  ask_s;
		logic [1:0]  fsk_s;
		logic [1:0]  ncs_s;
		logic [2:0]  rxt_s;
		logic [2:0]  err_s;
		logic [6:0]  flt_s1;
		logic [6:0]  flt_s2;
		logic        src_done;
		logic        src_xtal;
		logic [3:0]  edge_cnt;
		logic [7:0]  win_cnt;
		logic [6:0]  flags;
		logic        irq;
		logic [9:0]  car_cnt;
		logic [11:0] tx_len;
		logic [16:0] diag_cnt;
		logic [15:0] bit_cnt;
		logic        dout;
		logic [1:0]  drv;
		logic [1:0]  drv_oe;
		logic        pll_en;
		logic        sdo_oe;
		logic        uv;
		logic [15:0] resp;
	} lfi_sys_t;

	// Serial clock domain word store.
	typedef struct packed {
		logic [15:0] rx_word;
		logic        rx_tog;
		logic        err_tog;
	} lfi_link_t;

endpackage

// ---- hw/lfi_spi_link.sv ----
/*
 * Serial slave shifter running on the serial clock.
 * It assumes the clock idles while the chip select is high.
 */
`timescale 1ns/1ps
module lfi_spi_link
	import lfi_pkg::*;
(
	input  wire logic        sclk,
	input  wire logic        ncs,
	input  wire logic        rst_n,
	input  wire logic        sdi,
	input  wire logic [15:0] resp,
	output logic             sdo,
	output logic [15:0]      rx_word,
	output logic             rx_tog,
	output logic             err_tog
);

	logic [4:0]  cnt_reg;
	logic [15:0] rsh_reg;
	logic [15:0] tsh_reg;
	logic        frm_rst_n;
	lfi_link_t   st_reg;
	lfi_link_t   st_next;

	// A high chip select ends the frame and clears the bit position.
	assign frm_rst_n = rst_n & ~ncs;

	// Frame shifters, restarted by each frame's own select.
	always_ff @(posedge sclk or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			cnt_reg <= 5'h00;
			rsh_reg <= 16'h0000;
			tsh_reg <= 16'h0000;
		end else begin
			rsh_reg <= {rsh_reg[14:0], sdi};
			tsh_reg <= (cnt_reg == 5'h00) ? resp : {tsh_reg[14:0], 1'b0};
			if (cnt_reg != 5'h11) begin
				cnt_reg <= cnt_reg + 5'h01;
			end
		end
	end

	// The sixteenth bit completes a word; a seventeenth marks a framing error.
	always_comb begin
		st_next = st_reg;
		if (cnt_reg == 5'h0F) begin
			st_next.rx_word = {rsh_reg[14:0], sdi};
			st_next.rx_tog  = ~st_reg.rx_tog;
		end
		if (cnt_reg == 5'h10) begin
			st_next.err_tog = ~st_reg.err_tog;
		end
	end

	// Word store survives the end of the frame for the system side to fetch.
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sdo     = tsh_reg[15];
	assign rx_word = st_reg.rx_word;
	assign rx_tog  = st_reg.rx_tog;
	assign err_tog = st_reg.err_tog;

	chk_bit_count: assert property (@(posedge sclk) disable iff (!frm_rst_n)
		cnt_reg == 5'h0F |=> st_reg.rx_tog != $past(st_reg.rx_tog))
		else $error("Word toggle missing after sixteen bits.");

endmodule

// ---- hw/lfi_top.sv ----
/*
 * Mode control core of a two-channel low-frequency initiator: operating modes,
 * wake-up, clock source detection, carrier, modulation, demodulated data and flags.
 * It assumes synchronous fault comparators outside, a host acting as serial master
 * and an analogue driver stage that honours the per-channel output enables.
 */
// Functional notes
// - Sleep restores default configuration and clears flags and counters.
// - Sleep keeps drivers off, PLL down and ignores serial traffic.
// - A rising edge on the wake pin takes the device out of sleep.
// - Standby keeps drivers off, outputs at defaults, transmit chain idle.
// - Transmit drives outputs active and antennas per the selected configuration.
// - Commands accepted in standby, transmit, diagnosis; answers in standby, transmit.
// - Diagnosis sets outputs to defaults and enables both antenna drivers.
// - Internal clock multiplier follows a 2 MHz clock or 4 MHz crystal.
// - Clock source is recognised automatically at start-up.
// - Carrier is fixed 125 kHz or programmable 110 to 141.6 kHz.
// - Square drive duty selectable among four steps, 6.25 to 50 percent.
// - Each channel offers full-depth ASK and 0/180 degree PSK keying.
// - Amplitude demodulator bits appear on data pin at 2, 4 or 8 kbps.
// - Frequency demodulator bits appear on the same data pin.
// - Logic or driver supply under-voltage enters the under-voltage condition.
// - Separate flags for under-voltage, temperature, over-current and serial errors.
// - Diagnosis reports antenna shorts and open or detuned antenna.
// - Full-duplex serial link; host is master, device only a slave.
`timescale 1ns/1ps
module lfi_top
	import lfi_pkg::*;
#(
	parameter int DIAG_CYC   = DIAG_TIME_US * (CLK_HZ / 1000000),
	parameter int BIT_CYC_LO = CLK_HZ / RATE_LO_HZ,
	parameter int BIT_CYC_MD = CLK_HZ / RATE_MID_HZ,
	parameter int BIT_CYC_HI = CLK_HZ / RATE_HI_HZ
)
(
	input  wire logic       SYS_CLK,
	input  wire logic       RESET_N,
	input  wire logic       SCLK,
	input  wire logic       NCS,
	input  wire logic       SDI,
	output logic            SDO,
	output logic            SDO_OE,
	input  wire logic       WAKE_PIN,
	input  wire logic       CLK_IN,
	input  wire logic       RDI,
	input  wire logic       ASK_RX,
	input  wire logic       FSK_RX,
	input  wire logic [6:0] FAULT_IN,
	output logic [1:0]      ANT_DRV,
	output logic [1:0]      ANT_OE,
	output logic            PLL_EN,
	output logic            PLL_XTAL,
	output logic            D_OUT,
	output logic            IRQ,
	output logic [1:0]      MODE,
	output logic            UV_ACTIVE
);

	lfi_sys_t    st_reg;
	lfi_sys_t    st_next;
	logic [15:0] rx_word;
	logic        rx_tog;
	logic        err_tog;
	logic        clk_rise;
	logic        wake_rise;
	logic        cmd_hit;
	logic        err_hit;
	logic        bad_cmd;
	logic [3:0]  op;
	logic [11:0] arg;
	logic [6:0]  clr_mask;
	logic [6:0]  set_vec;
	logic [9:0]  per;
	logic [9:0]  per_prog;
	logic [9:0]  hi;
	logic        car_on;
	logic        car_wrap;
	logic        bit_wrap;
	logic [15:0] bit_top;
	logic        stop_fault;
	logic        uv_now;
	logic        rdi_now;
	logic [1:0]  ch_drv;
	logic [1:0]  ch_oe;

	// Serial shifter on the link clock; words come over by a toggle.
	lfi_spi_link u_link (
		.sclk    (SCLK),
		.ncs     (NCS),
		.rst_n   (RESET_N),
		.sdi     (SDI),
		.resp    (st_reg.resp),
		.sdo     (SDO),
		.rx_word (rx_word),
		.rx_tog  (rx_tog),
		.err_tog (err_tog)
	);

	// Edges and events seen after the two-stage synchronisers.
	assign clk_rise   = st_reg.clk_s[1] & ~st_reg.clk_s[2];
	assign wake_rise  = st_reg.wake_s[1] & ~st_reg.wake_s[2];
	assign cmd_hit    = st_reg.rxt_s[1] ^ st_reg.rxt_s[2];
	assign err_hit    = st_reg.err_s[1] ^ st_reg.err_s[2];
	assign op         = rx_word[WORD_W-1:OP_LSB];
	assign arg        = rx_word[OP_LSB-1:0];
	assign uv_now     = st_reg.flt_s2[FI_UVDD] | st_reg.flt_s2[FI_UVS];
	assign stop_fault = uv_now | st_reg.flt_s2[FI_OTMP] | st_reg.flt_s2[FI_OCUR];
	assign rdi_now    = st_reg.rdi_s[1];

	// Carrier period and high time from the selected frequency and duty.
	always_comb begin
		per_prog = PER_MIN + {2'b00, st_reg.cfg.per_code};
		if (per_prog > PER_MAX) begin
			per_prog = PER_MAX;
		end
		per = st_reg.cfg.fixed ? PER_FIXED : per_prog;
		case (st_reg.cfg.duty)
			2'h0:    hi = per >> 4;
			2'h1:    hi = per >> 3;
			2'h2:    hi = per >> 2;
			default: hi = per >> 1;
		endcase
		car_on   = st_reg.car_cnt < hi;
		car_wrap = st_reg.car_cnt >= per - 10'h001;
		case (st_reg.cfg.rate)
			2'h1:    bit_top = 16'(BIT_CYC_MD - 1);
			2'h2:    bit_top = 16'(BIT_CYC_HI - 1);
			default: bit_top = 16'(BIT_CYC_LO - 1);
		endcase
		bit_wrap = st_reg.bit_cnt >= bit_top;
	end

	// Per-channel keying and output enable.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			assign ch_oe[gi]  = (st_reg.mode == M_TX && st_reg.cfg.chan_en[gi])
				|| st_reg.mode == M_DIAG;
			assign ch_drv[gi] = (st_reg.mode == M_DIAG) ? car_on :
				((car_on ^ (st_reg.cfg.psk_en & rdi_now))
				& ~(st_reg.cfg.ask_en & ~rdi_now));
		end
	endgenerate

	// Next state of the whole core.
	always_comb begin
		st_next  = st_reg;
		clr_mask = 7'h00;
		bad_cmd  = 1'b0;

		// Synchronisers for pins and link toggles.
		st_next.clk_s  = {st_reg.clk_s[1:0], CLK_IN};
		st_next.wake_s = {st_reg.wake_s[1:0], WAKE_PIN};
		st_next.rdi_s  = {st_reg.rdi_s[0], RDI};
		st_next.ask_s  = {st_reg.ask_s[0], ASK_RX};
		st_next.fsk_s  = {st_reg.fsk_s[0], FSK_RX};
		st_next.ncs_s  = {st_reg.ncs_s[0], NCS};
		st_next.rxt_s  = {st_reg.rxt_s[1:0], rx_tog};
		st_next.err_s  = {st_reg.err_s[1:0], err_tog};
		st_next.flt_s1 = FAULT_IN;
		st_next.flt_s2 = st_reg.flt_s1;

		// Count input clock edges over a fixed window once after reset.
		if (!st_reg.src_done) begin
			if (clk_rise && st_reg.edge_cnt != 4'hF) begin
				st_next.edge_cnt = st_reg.edge_cnt + 4'h1;
			end
			if (st_reg.win_cnt == 8'(DET_WIN_CYC - 1)) begin
				st_next.src_done = 1'b1;
				st_next.src_xtal = st_reg.edge_cnt >= 4'(DET_XTAL_EDGES);
			end else begin
				st_next.win_cnt = st_reg.win_cnt + 8'h01;
			end
		end

		// Carrier counter runs only while the transmit chain is in use.
		if (st_reg.mode == M_TX || st_reg.mode == M_DIAG) begin
			st_next.car_cnt = car_wrap ? 10'h000 : st_reg.car_cnt + 10'h001;
		end else begin
			st_next.car_cnt = 10'h000;
		end

		// Demodulated data is resampled once per bit period during transmit.
		if (st_reg.mode == M_TX) begin
			st_next.bit_cnt = bit_wrap ? 16'h0000 : st_reg.bit_cnt + 16'h0001;
			if (bit_wrap) begin
				st_next.dout = st_reg.cfg.dsel ? st_reg.fsk_s[1] : st_reg.ask_s[1];
			end
		end else begin
			st_next.bit_cnt = 16'h0000;
			st_next.dout    = 1'b0;
		end

		// Command execution in every mode but sleep.
		if (st_reg.mode != M_SLEEP && cmd_hit) begin
			case (op)
				OP_NOP: begin
				end
				OP_CFG: begin
					st_next.cfg.fixed    = arg[CFG_FIXED_BIT];
					st_next.cfg.duty     = arg[CFG_DUTY_LSB+1:CFG_DUTY_LSB];
					st_next.cfg.per_code = arg[7:0];
				end
				OP_MOD: begin
					st_next.cfg.chan_en = arg[1:0];
					st_next.cfg.ask_en  = arg[MOD_ASK_BIT];
					st_next.cfg.psk_en  = arg[MOD_PSK_BIT];
					st_next.cfg.rate    = arg[MOD_RATE_LSB+1:MOD_RATE_LSB];
					st_next.cfg.dsel    = arg[MOD_DSEL_BIT];
				end
				OP_TX: begin
					if (st_reg.mode == M_STBY && !stop_fault) begin
						st_next.mode   = M_TX;
						st_next.tx_len = arg;
					end else begin
						bad_cmd = 1'b1;
					end
				end
				OP_DIAG: begin
					if (st_reg.mode == M_STBY && !uv_now) begin
						st_next.mode     = M_DIAG;
						st_next.diag_cnt = 17'(DIAG_CYC - 1);
					end else begin
						bad_cmd = 1'b1;
					end
				end
				OP_SLEEP: st_next.mode = M_SLEEP;
				OP_CLR:   clr_mask = arg[6:0];
				default:  bad_cmd = 1'b1;
			endcase
			st_next.resp = {st_reg.mode, st_reg.src_xtal, st_reg.uv,
				st_reg.flags, 5'h00};
		end

		// Activity completion and fault abort return to standby.
		case (st_reg.mode)
			M_TX: begin
				if (stop_fault) begin
					st_next.mode = M_STBY;
				end else if (car_wrap) begin
					if (st_reg.tx_len == 12'h000) begin
						st_next.mode = M_STBY;
					end else begin
						st_next.tx_len = st_reg.tx_len - 12'h001;
					end
				end
			end
			M_DIAG: begin
				if (st_reg.diag_cnt == 17'h0_0000 || uv_now) begin
					st_next.mode = M_STBY;
				end else begin
					st_next.diag_cnt = st_reg.diag_cnt - 17'h0_0001;
				end
			end
			default: begin
			end
		endcase

		// Sticky flags; a new event beats a clear in the same cycle.
		set_vec          = 7'h00;
		set_vec[FL_UV]   = uv_now;
		set_vec[FL_PREW] = st_reg.flt_s2[FI_PREW];
		set_vec[FL_OTMP] = st_reg.flt_s2[FI_OTMP];
		set_vec[FL_OCUR] = st_reg.flt_s2[FI_OCUR];
		set_vec[FL_SPI]  = (err_hit | bad_cmd) & (st_reg.mode != M_SLEEP);
		set_vec[FL_SHRT] = st_reg.flt_s2[FI_SHRT] & (st_reg.mode == M_DIAG);
		set_vec[FL_OPEN] = st_reg.flt_s2[FI_OPEN] & (st_reg.mode == M_DIAG);
		st_next.flags    = (st_reg.flags & ~clr_mask) | set_vec;
		st_next.irq      = |st_reg.flags;
		st_next.uv       = uv_now;

		// Registered pin drive.
		st_next.drv_oe = ch_oe;
		st_next.drv    = ch_drv & ch_oe;
		st_next.pll_en = st_reg.mode != M_SLEEP;
		st_next.sdo_oe = (st_reg.mode == M_STBY || st_reg.mode == M_TX)
			&& !st_reg.ncs_s[1];

		// Sleep holds everything at default and waits for the wake edge.
		if (st_reg.mode == M_SLEEP) begin
			st_next.cfg      = CFG_RST;
			st_next.flags    = 7'h00;
			st_next.tx_len   = 12'h000;
			st_next.diag_cnt = 17'h0_0000;
			st_next.resp     = 16'h0000;
			st_next.sdo_oe   = 1'b0;
			st_next.mode     = wake_rise ? M_STBY : M_SLEEP;
		end
	end

	// Single state register of the core.
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_reg        <= '0;
			st_reg.cfg    <= CFG_RST;
			st_reg.mode   <= M_SLEEP;
			st_reg.wake_s <= 3'b111; // A pin already high at release is no edge.
		end else begin
			st_reg <= st_next;
		end
	end

	// Ports come straight from the state register.
	assign SDO_OE    = st_reg.sdo_oe;
	assign ANT_DRV   = st_reg.drv;
	assign ANT_OE    = st_reg.drv_oe;
	assign PLL_EN    = st_reg.pll_en;
	assign PLL_XTAL  = st_reg.src_xtal;
	assign D_OUT     = st_reg.dout;
	assign IRQ       = st_reg.irq;
	assign MODE      = st_reg.mode;
	assign UV_ACTIVE = st_reg.uv;

	chk_sleep_hiz: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		$past(st_reg.mode) == M_SLEEP && st_reg.mode == M_SLEEP
		|-> st_reg.drv_oe == 2'h0 && !st_reg.pll_en && !st_reg.sdo_oe)
		else $error("Sleep left a driver or the PLL on.");

	chk_sleep_clear: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		st_reg.mode == M_SLEEP |=> st_reg.flags == 7'h00 && st_reg.cfg == CFG_RST)
		else $error("Sleep did not restore defaults.");

	chk_wake_exit: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		st_reg.mode == M_SLEEP && wake_rise |=> st_reg.mode == M_STBY)
		else $error("Wake edge did not leave sleep.");

	chk_stby_idle: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		st_reg.mode == M_STBY [*2] |-> st_reg.drv_oe == 2'h0 && !st_reg.dout)
		else $error("Standby left outputs active.");

	chk_diag_drive: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		st_reg.mode == M_DIAG [*2] |-> st_reg.drv_oe == 2'h3 && !st_reg.dout)
		else $error("Diagnosis drivers not enabled.");

	chk_diag_end: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		st_reg.mode == M_DIAG && st_reg.diag_cnt == 17'h0_0000 |=> st_reg.mode == M_STBY)
		else $error("Diagnosis did not end in standby.");

	chk_uv_stop: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		st_reg.mode == M_TX && uv_now |=> st_reg.mode == M_STBY && st_reg.uv)
		else $error("Under-voltage did not stop transmit.");

	chk_flag_sticky: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		st_reg.mode != M_SLEEP && !(cmd_hit && op == OP_CLR)
		|=> (st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags))
		else $error("A flag dropped without a clear.");

	chk_irq_flag: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
		$rose(|st_reg.flags) |=> IRQ)
		else $error("Interrupt missing after a flag.");

endmodule

// ---- verif/lfi_host_model.sv ----
/*
 * Host microcontroller model acting as serial master of the mode control core.
 * It assumes the caller starts a frame only after the previous one has settled.
 */
`timescale 1ns/1ps
module lfi_host_model
	import lfi_pkg::*;
#(
	parameter realtime HALF_NS = 62.5
)
(
	output logic      sclk,
	output logic      ncs,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	// The serial clock stands low between frames.
	initial begin
		sclk = 1'b0;
		ncs  = 1'b1;
		sdi  = 1'b0;
	end

	// One frame, MSB first; an extra bit makes an over-long frame on purpose.
	task automatic xfer(input logic [15:0] w, input bit extra, output logic [15:0] r);
		int          i;
		int          n;
		logic [16:0] sh;
		logic        seen;
		n    = extra ? 17 : 16;
		sh   = {w, 1'b0};
		seen = 1'b0;
		#7;
		ncs = 1'b0;
		for (i = 0; i < n; i++) begin
			sdi = sh[16];
			sh  = sh << 1;
			#(HALF_NS) sclk = 1'b1;
			#(HALF_NS) sclk = 1'b0;
			// An undriven line shows the inverse of the last bit seen.
			seen = sdo_oe ? sdo : ~seen;
			r    = {r[14:0], seen};
		end
		#(HALF_NS) ncs = 1'b1;
		sdi = ~sdi;
	endtask
endmodule

// ---- verif/lfi_top_tb.sv ----
/*
 * Self-checking bench of the mode control core with a serial host model.
 * It assumes shortened diagnosis and bit periods, set at the instance.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 16'(e), 16'(g));
module lfi_top_tb
	import lfi_pkg::*;
;
	logic        SYS_CLK, RESET_N, WAKE_PIN, CLK_IN, RDI, ASK_RX, FSK_RX;
	logic [6:0]  FAULT_IN;
	wire         SCLK, NCS, SDI;
	logic        SDO, SDO_OE, PLL_EN, PLL_XTAL, D_OUT, IRQ, UV_ACTIVE;
	logic [1:0]  ANT_DRV, ANT_OE, MODE;
	int          n_errors, cmp_count, cyc, clk_half, cin_cnt;
	logic        xt;
	logic [15:0] r;
	int          seed = 32'hce6b;

	lfi_top #(.DIAG_CYC(200), .BIT_CYC_LO(40), .BIT_CYC_MD(20), .BIT_CYC_HI(10)) i_dut (
		.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .SCLK(SCLK), .NCS(NCS), .SDI(SDI),
		.SDO(SDO), .SDO_OE(SDO_OE), .WAKE_PIN(WAKE_PIN), .CLK_IN(CLK_IN), .RDI(RDI),
		.ASK_RX(ASK_RX), .FSK_RX(FSK_RX), .FAULT_IN(FAULT_IN), .ANT_DRV(ANT_DRV),
		.ANT_OE(ANT_OE), .PLL_EN(PLL_EN), .PLL_XTAL(PLL_XTAL), .D_OUT(D_OUT), .IRQ(IRQ),
		.MODE(MODE), .UV_ACTIVE(UV_ACTIVE));

	lfi_host_model i_host (.sclk(SCLK), .ncs(NCS), .sdi(SDI), .sdo(SDO), .sdo_oe(SDO_OE));

	// System clock at 100 MHz.
	initial begin
		SYS_CLK = 1'b0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	// Clock input source; the half period picks 2 MHz or near 4 MHz.
	always @(posedge SYS_CLK) begin
		if (cin_cnt >= clk_half) begin
			cin_cnt <= 0;
			CLK_IN  <= ~CLK_IN;
		end else begin
			cin_cnt <= cin_cnt + 1;
		end
	end

	// Cuts a hung run short.
	always @(posedge SYS_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_errors++;
			end_sim();
		end
	end

	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		$display("Errors %0d, comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask

	task automatic setf(input logic [6:0] v);
		@(posedge SYS_CLK) FAULT_IN <= v;
	endtask

	task automatic cmd(input logic [15:0] w, output logic [15:0] q);
		i_host.xfer(w, 1'b0, q);
		tick(15);
	endtask

	// Two status frames; the second returns the snapshot of the first.
	task automatic st(output logic [15:0] q);
		cmd(16'h0000, q);
		cmd(16'h0000, q);
	endtask

	task automatic wait_mode(input lfi_mode_t m, input int lim);
		int k;
		for (k = 0; k < lim && MODE !== m; k++) tick(1);
		// Pins follow the mode register one cycle later.
		tick(1);
	endtask

	function automatic logic [15:0] exp_st(logic [1:0] m, logic uv, logic [6:0] f);
		return {m, xt, uv, f, 5'h00};
	endfunction

	task automatic do_reset(input int half, input logic x);
		@(posedge SYS_CLK) begin
			RESET_N  <= 1'b0;
			clk_half <= half;
		end
		tick(16);
		@(posedge SYS_CLK) RESET_N <= 1'b1;
		tick(250);
		xt = x;
		`CHK("pll_xtal", x, PLL_XTAL)
		`CHK("mode_rst", M_SLEEP, MODE)
		`CHK("pll_sleep", 1'b0, PLL_EN)
		`CHK("oe_sleep", 2'h0, ANT_OE)
	endtask

	task automatic wake();
		@(posedge SYS_CLK) WAKE_PIN <= 1'b0;
		tick(4);
		@(posedge SYS_CLK) WAKE_PIN <= 1'b1;
		tick(8);
		`CHK("mode_wake", M_STBY, MODE)
		`CHK("pll_wake", 1'b1, PLL_EN)
	endtask

	// Main sequence.
	initial begin
		int          c, k, hi, pc, per, eh, fl;
		logic [1:0]  d, ch;
		logic        fx, av;
		logic [7:0]  code;
		{RESET_N, WAKE_PIN, CLK_IN, RDI, ASK_RX, FSK_RX, FAULT_IN} = '0;
		{n_errors, cmp_count, cyc, cin_cnt} = '0;
		clk_half = 24;
		do_reset(24, 1'b0);
		wake();
		st(r);
		`CHK("status", exp_st(M_STBY, 1'b0, 7'h00), r)
		do_reset(12, 1'b1);
		wake();
		// Each fault input but short and open raises its flag and the interrupt; both supply inputs share one flag.
		for (c = 0; c < 5; c++) begin
			fl = (c < 2) ? 0 : c - 1;
			setf(7'(1 << c));
			tick(8);
			`CHK("irq_set", 1'b1, IRQ)
			`CHK("uv", c < 2, UV_ACTIVE)
			st(r);
			`CHK("flags", exp_st(M_STBY, c < 2, 7'(1 << fl)), r)
			setf(7'h00);
			cmd({OP_CLR, 12'h07f}, r);
			`CHK("irq_clr", 1'b0, IRQ)
		end
		// Over-long frame and unknown opcode both flag a serial error.
		for (c = 0; c < 2; c++) begin
			i_host.xfer((c == 0) ? 16'h0000 : 16'hf000, c == 0, r);
			tick(15);
			`CHK("spi_err_irq", 1'b1, IRQ)
			cmd({OP_CLR, 12'h07f}, r);
		end
		// Duty, carrier period, keying and demodulated data per case.
		for (c = 0; c < 6; c++) begin
			d    = (c < 4) ? 2'(c) : 2'h0;
			fx   = c[0] | (c > 3);
			code = 8'($random(seed));
			per  = fx ? 800 : ((707 + int'(code) > 909) ? 909 : 707 + int'(code));
			ch   = (c < 4) ? {1'($random(seed)), 1'b1} : 2'h3;
			av   = 1'($random(seed));
			@(posedge SYS_CLK) begin
				ASK_RX <= av;
				FSK_RX <= ~av;
				RDI    <= (c != 4);
			end
			cmd({OP_CFG, fx, d, 1'b0, code}, r);
			cmd({OP_MOD, 5'h00, c[0], 2'(c % 3), c == 5, c == 4, ch}, r);
			cmd({OP_TX, 12'h003}, r);
			`CHK("mode_tx", M_TX, MODE)
			`CHK("oe_tx", ch, ANT_OE)
			hi = 0;
			pc = 0;
			if (c == 4) begin
				repeat (1000) begin
					tick(1);
					if (ANT_DRV[0] !== 1'b0) hi++;
				end
				`CHK("ask_blank", 0, hi)
			end else begin
				for (k = 0; k < 1000 && ANT_DRV[0] !== 1'b0; k++) tick(1);
				for (k = 0; k < 1000 && ANT_DRV[0] !== 1'b1; k++) tick(1);
				while (ANT_DRV[0] === 1'b1 && hi < 1000) begin
					tick(1);
					hi++;
				end
				pc = hi;
				while (ANT_DRV[0] !== 1'b1 && pc < 1000) begin
					tick(1);
					pc++;
				end
				eh = per >> (4 - d);
				if (c == 5) eh = per - eh;
				`CHK("high_time", eh, hi)
				`CHK("period", per, pc)
			end
			`CHK("demod", c[0] ^ av, D_OUT)
			wait_mode(M_STBY, 4000);
			`CHK("mode_done", M_STBY, MODE)
			`CHK("oe_stby", 2'h0, ANT_OE)
			`CHK("dout_stby", 1'b0, D_OUT)
		end
		// Diagnosis drives both channels and reports antenna faults.
		cmd({OP_DIAG, 12'h000}, r);
		`CHK("mode_diag", M_DIAG, MODE)
		`CHK("oe_diag", 2'h3, ANT_OE)
		`CHK("dout_diag", 1'b0, D_OUT)
		setf(7'h60);
		tick(8);
		setf(7'h00);
		wait_mode(M_STBY, 300);
		`CHK("diag_end", M_STBY, MODE)
		st(r);
		`CHK("diag_flags", exp_st(M_STBY, 1'b0, 7'h60), r)
		// Under-voltage cuts transmit short and refuses a new start.
		cmd({OP_TX, 12'h003}, r);
		`CHK("mode_tx3", M_TX, MODE)
		setf(7'h01);
		tick(8);
		`CHK("uv_abort", M_STBY, MODE)
		cmd({OP_TX, 12'h003}, r);
		`CHK("tx_refused", M_STBY, MODE)
		st(r);
		`CHK("uv_flags", exp_st(M_STBY, 1'b1, 7'h71), r)
		setf(7'h00);
		// Sleep clears flags and settings and ignores frames.
		cmd({OP_MOD, 12'h003}, r);
		setf(7'h04);
		tick(8);
		setf(7'h00);
		cmd({OP_SLEEP, 12'h000}, r);
		`CHK("mode_sleep", M_SLEEP, MODE)
		`CHK("irq_sleep", 1'b0, IRQ)
		`CHK("pll_off", 1'b0, PLL_EN)
		cmd({OP_MOD, 12'h003}, r);
		`CHK("sdo_sleep", 1'b0, SDO_OE)
		`CHK("sdo_sleep_bus", 16'haaaa, r)
		wake();
		cmd({OP_TX, 12'h000}, r);
		`CHK("mode_tx2", M_TX, MODE)
		`CHK("oe_default", 2'h0, ANT_OE)
		wait_mode(M_STBY, 1000);
		st(r);
		`CHK("flags_cleared", exp_st(M_STBY, 1'b0, 7'h00), r)
		end_sim();
	end
endmodule
